// ==== hdl/wsm_top.sv ====
// Purpose: warning qualification, recovery, lamp, actions, valve protection
// Assumes: wishbone classic slave, inputs synchronous to ref_clk
// Notes: one ms tick drives all delays and lamp patterns
// Overview of operation
// - warning reported after rise delay, default 2000ms
// - warning cleared after fall delay, default 2000ms
// - active warning flashes lamp twice per second
// - recovery mode auto/resettable/off, global or individual
// - automatic mode returns status to clear
// - resettable mode latches past event, slow flash
// - off mode gives no notification
// - acknowledge request clears past events and slow flash
// - error lights lamp steadily, error status set
// - status active, past, clear or disabled
// - individual rise, fall, mode override global
// - action fires on rising, falling or both
// - actions: reset, measure, valve, setpoint, switch
// - release action cancels valve override
// - zero and full setpoint actions ignored when analog-only
// - open valve, no flow 20s: protect, 75%
// - flow returns: protection ends
// - switch by command or warning action
// - setting disables valve protection
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "wsm_consts.svh"
module wsm_top import wsm_pkg::*; #(
  parameter int N = 4,
  parameter int MS_CYC = `WSM_MS_CYC,
  parameter int VPROT_MS = `WSM_VPROT_MS
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic ce,
  // wishbone
  input wire logic wb_cyc,
  input wire logic wb_stb,
  input wire logic wb_we,
  input wire logic [7:0] wb_adr,
  input wire logic [3:0] wb_sel,
  input wire logic [31:0] wb_dat_wr,
  output logic [31:0] wb_dat_rd,
  output logic wb_ack,
  // process conditions
  input wire logic [N-1:0] warn_cond,
  input wire logic err_det,
  input wire logic btn_reset,
  input wire logic flow_zero,
  input wire logic valve_full,
  input wire logic sp_nonzero,
  // notifications and actions
  output logic lamp_red,
  output logic vprot_warn,
  output logic [6:0] drive_limit_pct,
  output logic [1:0] valve_ovr,
  output logic sw_out,
  output logic meas_run,
  output logic dev_reset,
  output logic sp_stb,
  output logic [1:0] sp_code
);
  localparam logic [15:0] PRE_MAX = 16'(MS_CYC - 1);
  localparam logic [15:0] VP_MAX = 16'(VPROT_MS - 1);
  // ****************************************
  // state
  // ****************************************
  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    logic [15:0] pre;
    logic tick;
    logic [9:0] lms;
    logic [N-1:0] act;
    logic [N-1:0] past;
    logic [N-1:0][15:0] cnt;
    logic [31:0] ctrl;
    logic [31:0] gdly;
    logic [N-1:0][31:0] wcfg;
    logic [N-1:0][31:0] wdly;
    logic err;
    logic lamp;
    logic vprot;
    logic [15:0] vcnt;
    logic sw;
    wsm_vovr_t vovr;
    logic meas;
    logic drst;
    wsm_sp_t spc;
    logic sps;
  } wsm_st_t;

  wsm_st_t s, n;

  function automatic logic [31:0] wmerge(input logic [31:0] o, input logic [31:0] d,
                                         input logic [3:0] sel);
    logic [31:0] r;
    r = o;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = d[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // individual mode wins over the global one
  function automatic wsm_mode_t eff_mode(input logic [31:0] c, input logic [31:0] g);
    logic [1:0] m;
    m = c[`WSM_WC_CMODE] ? c[`WSM_WC_MLO +: 2] : g[`WSM_CTRL_MLO +: 2];
    // the unused code behaves as off, so no stray notification can appear
    return (m == 2'h3) ? WSM_OFF : wsm_mode_t'(m);
  endfunction

  // ****************************************
  // next state
  // ****************************************
  always_comb begin : comb
    logic take, wr, clr, wsel, en, re, fe, fast, slow, any_act, any_past, vcond;
    logic [4:0] wi;
    logic [15:0] dly;
    logic [31:0] stv;
    wsm_mode_t md;
    wsm_act_t ac;
    wsm_stat_t sc;
    take = 1'b0;
    wr = 1'b0;
    clr = 1'b0;
    wsel = 1'b0;
    wi = '0;
    dly = '0;
    en = 1'b0;
    re = 1'b0;
    fe = 1'b0;
    fast = 1'b0;
    slow = 1'b0;
    any_act = 1'b0;
    any_past = 1'b0;
    vcond = 1'b0;
    stv = '0;
    md = WSM_AUTO;
    ac = WSM_A_NONE;
    sc = WSM_ST_CLEAR;
    n = s;
    n.drst = 1'b0;
    n.sps = 1'b0;
    // ms timebase and lamp phase
    n.tick = 1'b0;
    if (s.pre >= PRE_MAX) begin
      n.pre = '0;
      n.tick = 1'b1;
    end else begin
      n.pre = s.pre + 16'h0001;
    end
    if (s.tick) begin
      n.lms = (s.lms >= `WSM_LAMP_MS - 10'h001) ? '0 : s.lms + 10'h001;
    end
    // bus access, answered one cycle after the request
    take = wb_cyc & wb_stb & ~s.ack;
    wr = take & wb_we;
    n.ack = take;
    wi = 5'(wb_adr[7:3] - `WSM_WIDX_BIAS);
    wsel = (wb_adr >= `WSM_WBASE_OFS) && (32'(wi) < N);
    if (wr) begin
      if (wb_adr == `WSM_CTRL_OFS) begin
        n.ctrl = wmerge(s.ctrl, wb_dat_wr, wb_sel) & `WSM_CTRL_MASK;
        if (wb_sel[0]) begin
          n.sw = wb_dat_wr[`WSM_CTRL_SW];
        end
      end else if (wb_adr == `WSM_GDLY_OFS) begin
        n.gdly = wmerge(s.gdly, wb_dat_wr, wb_sel);
      end else if (wsel && wb_adr[2]) begin
        n.wdly[wi] = wmerge(s.wdly[wi], wb_dat_wr, wb_sel);
      end else if (wsel) begin
        n.wcfg[wi] = wmerge(s.wcfg[wi], wb_dat_wr, wb_sel) & `WSM_WCFG_MASK;
      end
    end
    clr = btn_reset | (wr && wb_adr == `WSM_CTRL_OFS && wb_sel[0] &&
                       wb_dat_wr[`WSM_CTRL_CLR]);
    // per-warning qualification, recovery and actions
    for (int i = 0; i < N; i++) begin
      en = s.wcfg[i][`WSM_WC_EN];
      md = eff_mode(s.wcfg[i], s.ctrl);
      if (s.wcfg[i][`WSM_WC_CDLY]) begin
        dly = s.act[i] ? s.wdly[i][31:16] : s.wdly[i][15:0];
      end else begin
        dly = s.act[i] ? s.gdly[31:16] : s.gdly[15:0];
      end
      if (!en) begin
        n.act[i] = 1'b0;
        n.cnt[i] = '0;
      end else if (warn_cond[i] == s.act[i]) begin
        n.cnt[i] = '0; // any break restarts the delay
      end else if (s.tick) begin
        if (s.cnt[i] + 16'h0001 >= dly) begin
          n.act[i] = ~s.act[i];
          n.cnt[i] = '0;
        end else begin
          n.cnt[i] = s.cnt[i] + 16'h0001;
        end
      end
      re = ~s.act[i] & n.act[i];
      fe = s.act[i] & ~n.act[i];
      if (clr || !en) begin
        n.past[i] = 1'b0;
      end
      // set wins over a clear in the same cycle; auto and off never latch
      if (fe && en && md == WSM_RESET) begin
        n.past[i] = 1'b1;
      end
      if (en && md != WSM_OFF) begin
        any_act = any_act | s.act[i];
        any_past = any_past | s.past[i];
      end
      if (!en) begin
        sc = WSM_ST_DIS;
      end else if (md == WSM_OFF) begin
        sc = WSM_ST_CLEAR;
      end else if (s.act[i]) begin
        sc = WSM_ST_ACTIVE;
      end else if (s.past[i]) begin
        sc = WSM_ST_PAST;
      end else begin
        sc = WSM_ST_CLEAR;
      end
      stv[2*i +: 2] = sc;
      // later warnings win when two fire in the same cycle
      ac = wsm_act_t'(s.wcfg[i][`WSM_WC_ALO +: 4]);
      if (en && ((re && s.wcfg[i][`WSM_WC_ONR]) || (fe && s.wcfg[i][`WSM_WC_ONF]))) begin
        unique case (ac)
          WSM_A_NONE: begin
          end
          WSM_A_DEVRST: n.drst = 1'b1;
          WSM_A_STOP: n.meas = 1'b0;
          WSM_A_START: n.meas = 1'b1;
          WSM_A_VCLOSE: n.vovr = WSM_V_CLOSE;
          WSM_A_VOPEN: n.vovr = WSM_V_OPEN;
          WSM_A_VREL: n.vovr = WSM_V_NORM;
          WSM_A_SP0: begin
            if (!s.ctrl[`WSM_CTRL_SPAN]) begin
              n.sps = 1'b1;
              n.spc = WSM_SP_ZERO;
            end
          end
          WSM_A_SPFULL: begin
            if (!s.ctrl[`WSM_CTRL_SPAN]) begin
              n.sps = 1'b1;
              n.spc = WSM_SP_FULL;
            end
          end
          WSM_A_SPPON: begin
            n.sps = 1'b1;
            n.spc = WSM_SP_PON;
          end
          WSM_A_SWCLOSE: n.sw = 1'b1;
          WSM_A_SWOPEN: n.sw = 1'b0;
          default: begin
          end
        endcase
      end
    end
    // valve overheat protection
    vcond = s.ctrl[`WSM_CTRL_VPEN] & sp_nonzero & valve_full & flow_zero;
    if (!s.ctrl[`WSM_CTRL_VPEN] || !flow_zero) begin
      n.vprot = 1'b0;
      n.vcnt = '0;
    end else if (!vcond && !s.vprot) begin
      n.vcnt = '0;
    end else if (vcond && !s.vprot && s.tick) begin
      if (s.vcnt >= VP_MAX) begin
        n.vprot = 1'b1;
      end else begin
        n.vcnt = s.vcnt + 16'h0001;
      end
    end
    any_act = any_act | s.vprot;
    // lamp: steady error, then fast, then slow
    n.err = err_det;
    fast = (s.lms < `WSM_FAST_HALF) ||
           ((s.lms >= `WSM_SLOW_HALF) && (s.lms < `WSM_SLOW_HALF + `WSM_FAST_HALF));
    slow = s.lms < `WSM_SLOW_HALF;
    if (s.err) begin
      n.lamp = 1'b1;
    end else if (any_act) begin
      n.lamp = fast;
    end else if (any_past) begin
      n.lamp = slow;
    end else begin
      n.lamp = 1'b0;
    end
    stv[`WSM_ST_ERR] = s.err;
    stv[`WSM_ST_LAMP] = s.lamp;
    stv[`WSM_ST_VPROT] = s.vprot;
    stv[`WSM_ST_SW] = s.sw;
    stv[`WSM_ST_VLO +: 2] = s.vovr;
    stv[`WSM_ST_MEAS] = s.meas;
    // read data; unmapped addresses read zero
    n.rdat = '0;
    if (take && !wb_we) begin
      if (wb_adr == `WSM_CTRL_OFS) begin
        n.rdat = s.ctrl;
      end else if (wb_adr == `WSM_GDLY_OFS) begin
        n.rdat = s.gdly;
      end else if (wb_adr == `WSM_STAT_OFS) begin
        n.rdat = stv;
      end else if (wsel && wb_adr[2]) begin
        n.rdat = s.wdly[wi];
      end else if (wsel) begin
        n.rdat = s.wcfg[wi];
      end
    end
  end

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      s <= '0;
      s.ctrl <= `WSM_CTRL_RST;
      s.gdly <= {`WSM_FALL_MS, `WSM_RISE_MS};
      s.wcfg <= {N{`WSM_WCFG_RST}};
      s.wdly <= {N{`WSM_FALL_MS, `WSM_RISE_MS}};
      s.meas <= 1'b1;
    end else if (ce) begin
      s <= n;
    end
  end

  assign wb_ack = s.ack;
  assign wb_dat_rd = s.rdat;
  assign lamp_red = s.lamp;
  assign vprot_warn = s.vprot;
  // the limit only tells the valve driver; the loop itself is outside
  assign drive_limit_pct = s.vprot ? `WSM_VLIM_PCT : `WSM_VFULL_PCT;
  assign valve_ovr = s.vovr;
  assign sw_out = s.sw;
  assign meas_run = s.meas;
  assign dev_reset = s.drst;
  assign sp_stb = s.sps;
  assign sp_code = s.spc;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_rise_hold;
    (!warn_cond[0] && !s.act[0]) |=> !s.act[0];
  endproperty
  a_rise_hold: assert property (p_rise_hold) else $error("warning rose without cause");
  property p_fall_hold;
    (warn_cond[0] && s.act[0] && s.wcfg[0][`WSM_WC_EN]) |=> s.act[0];
  endproperty
  a_fall_hold: assert property (p_fall_hold) else $error("warning fell while cond high");
  property p_fast_on;
    (ce && !s.err && (s.vprot || (s.act[0] && eff_mode(s.wcfg[0], s.ctrl) != WSM_OFF)) &&
     s.lms == 10'h064) |=> lamp_red;
  endproperty
  a_fast_on: assert property (p_fast_on) else $error("fast flash not lit");
  property p_fast_off;
    (ce && !s.err && (s.vprot || (s.act[0] && eff_mode(s.wcfg[0], s.ctrl) != WSM_OFF)) &&
     s.lms == 10'h12c) |=> !lamp_red;
  endproperty
  a_fast_off: assert property (p_fast_off) else $error("fast flash not dark");
  sequence s_err_seen;
    ce && err_det ##1 ce;
  endsequence
  property p_err_lamp;
    s_err_seen |=> lamp_red;
  endproperty
  a_err_lamp: assert property (p_err_lamp) else $error("error lamp not steady");
  property p_past_hold;
    (s.past[1] && !btn_reset && !wb_cyc && s.wcfg[1][`WSM_WC_EN]) |=> s.past[1];
  endproperty
  a_past_hold: assert property (p_past_hold) else $error("past event lost");
  property p_clr;
    (ce && btn_reset && !s.act[1]) |=> !s.past[1];
  endproperty
  a_clr: assert property (p_clr) else $error("past event not cleared");
  property p_vp_start;
    $rose(s.vprot) |-> $past(s.vcnt) == VP_MAX;
  endproperty
  a_vp_start: assert property (p_vp_start) else $error("protection started early");
  property p_vp_end;
    (ce && !flow_zero) |=> !s.vprot;
  endproperty
  a_vp_end: assert property (p_vp_end) else $error("protection kept with flow");
  property p_vp_dis;
    (ce && !s.ctrl[`WSM_CTRL_VPEN]) |=> (!s.vprot && drive_limit_pct == `WSM_VFULL_PCT);
  endproperty
  a_vp_dis: assert property (p_vp_dis) else $error("protection while disabled");
endmodule // wsm_top
`default_nettype wire

// ==== include/wsm_consts.svh ====
// Purpose: constants of the warning status manager
// Assumes: 40 MHz ref_clk
// Notes: offsets are byte addresses on the bus
`ifndef WSM_CONSTS_SVH
`define WSM_CONSTS_SVH
// ****************************************
// timing
// ****************************************
`define WSM_CLK_NS 25
`define WSM_MS_NS 1000000
`define WSM_MS_CYC (`WSM_MS_NS / `WSM_CLK_NS)
`define WSM_RISE_MS 16'h07d0
`define WSM_FALL_MS 16'h07d0
`define WSM_VPROT_S 20
`define WSM_VPROT_MS (`WSM_VPROT_S * 1000)
`define WSM_LAMP_MS 10'h3e8
`define WSM_FAST_HALF 10'h0fa
`define WSM_SLOW_HALF 10'h1f4
`define WSM_VLIM_PCT 7'h4b
`define WSM_VFULL_PCT 7'h64
// ****************************************
// register map
// ****************************************
`define WSM_CTRL_OFS 8'h00
`define WSM_GDLY_OFS 8'h04
`define WSM_STAT_OFS 8'h08
`define WSM_WBASE_OFS 8'h10
`define WSM_WIDX_BIAS 5'h02
`define WSM_CTRL_CLR 0
`define WSM_CTRL_SW 1
`define WSM_CTRL_VPEN 2
`define WSM_CTRL_SPAN 3
`define WSM_CTRL_MLO 4
`define WSM_CTRL_RST 32'h0000_0004
`define WSM_CTRL_MASK 32'h0000_003e
`define WSM_WC_EN 0
`define WSM_WC_CDLY 1
`define WSM_WC_CMODE 2
`define WSM_WC_MLO 3
`define WSM_WC_ALO 5
`define WSM_WC_ONR 9
`define WSM_WC_ONF 10
`define WSM_WCFG_RST 32'h0000_0001
`define WSM_WCFG_MASK 32'h0000_07ff
`define WSM_ST_ERR 24
`define WSM_ST_LAMP 25
`define WSM_ST_VPROT 26
`define WSM_ST_SW 27
`define WSM_ST_VLO 28
`define WSM_ST_MEAS 30
`endif

// ==== include/wsm_pkg.sv ====
// Purpose: types of the warning status manager
// Assumes: nothing
// Notes: enums only
`default_nettype none
package wsm_pkg;
  typedef enum logic [1:0] {WSM_AUTO, WSM_RESET, WSM_OFF} wsm_mode_t;
  typedef enum logic [1:0] {WSM_ST_CLEAR, WSM_ST_ACTIVE, WSM_ST_PAST, WSM_ST_DIS} wsm_stat_t;
  typedef enum logic [3:0] {
    WSM_A_NONE, WSM_A_DEVRST, WSM_A_STOP, WSM_A_START,
    WSM_A_VCLOSE, WSM_A_VOPEN, WSM_A_VREL, WSM_A_SP0,
    WSM_A_SPFULL, WSM_A_SPPON, WSM_A_SWCLOSE, WSM_A_SWOPEN
  } wsm_act_t;
  typedef enum logic [1:0] {WSM_V_NORM, WSM_V_CLOSE, WSM_V_OPEN} wsm_vovr_t;
  typedef enum logic [1:0] {WSM_SP_ZERO, WSM_SP_FULL, WSM_SP_PON} wsm_sp_t;
endpackage
`default_nettype wire

// ==== bench/wsm_host.sv ====
// Purpose: host model, a classic wishbone master
// Assumes: single ref_clk domain
// Notes: carries configuration, switch and acknowledge writes
`timescale 1ns/10ps
`default_nettype none
module wsm_host (
  // clock
  input wire logic ref_clk,
  // wishbone master side
  output logic wb_cyc,
  output logic wb_stb,
  output logic wb_we,
  output logic [7:0] wb_adr,
  output logic [3:0] wb_sel,
  output logic [31:0] wb_dat_wr,
  input wire logic [31:0] wb_dat_rd,
  input wire logic wb_ack
);
  initial begin
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_wr} = '0;
  end
  // request held until ack is sampled; acknowledge and switch commands travel here
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    @(posedge ref_clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_sel, wb_dat_wr} <= {2'b11, w, a, 4'hf, d};
    do @(posedge ref_clk); while (wb_ack !== 1'b1);
    q = wb_dat_rd;
    {wb_cyc, wb_stb, wb_we} <= 3'b000;
    // released data lines must not keep showing the old word
    wb_dat_wr <= ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    xfer(1'b0, a, 32'h0, q);
  endtask
endmodule // wsm_host
`default_nettype wire

// ==== bench/warning_status_manager_test.sv ====
// Purpose: self-checking bench of the warning status manager
// Assumes: ms tick shortened to 4 clocks, valve protection to 10 ticks
// Notes: lamp period is 1000 ticks, so 4000 clocks here
`timescale 1ns/10ps
`default_nettype none
module warning_status_manager_test import wsm_pkg::*;;
  logic ref_clk, rst_n, ce, wb_cyc, wb_stb, wb_we, wb_ack;
  logic [7:0] wb_adr;
  logic [3:0] wb_sel, warn_cond;
  logic [31:0] wb_dat_wr, wb_dat_rd, q;
  logic err_det, btn_reset, flow_zero, valve_full, sp_nonzero;
  logic lamp_red, vprot_warn, sw_out, meas_run, dev_reset, sp_stb;
  logic [6:0] drive_limit_pct;
  logic [1:0] valve_ovr, sp_code;
  int errors = 0, compares = 0, cycles = 0, dev_cnt = 0, sp_cnt = 0, r, l;
  // observed {dev pulse, sp pulse, meas_run, valve_ovr, sp_code, sw_out} per action code
  logic [7:0] exp_obs [1:11] = '{8'ha0, 8'h00, 8'h20, 8'h28, 8'h30, 8'h20,
                                 8'h60, 8'h62, 8'h64, 8'h25, 8'h24};
  wsm_top #(.N(4), .MS_CYC(4), .VPROT_MS(10)) DUT (.ref_clk(ref_clk), .rst_n(rst_n),
    .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we), .wb_adr(wb_adr),
    .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd), .wb_ack(wb_ack),
    .warn_cond(warn_cond), .err_det(err_det), .btn_reset(btn_reset),
    .flow_zero(flow_zero), .valve_full(valve_full), .sp_nonzero(sp_nonzero),
    .lamp_red(lamp_red), .vprot_warn(vprot_warn), .drive_limit_pct(drive_limit_pct),
    .valve_ovr(valve_ovr), .sw_out(sw_out), .meas_run(meas_run), .dev_reset(dev_reset),
    .sp_stb(sp_stb), .sp_code(sp_code));
  wsm_host host (.ref_clk(ref_clk), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_wr(wb_dat_wr), .wb_dat_rd(wb_dat_rd),
    .wb_ack(wb_ack));
  // ****************************************
  // clock, pulse counters, timeout
  // ****************************************
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles <= cycles + 1;
    if (dev_reset === 1'b1) dev_cnt <= dev_cnt + 1;
    if (sp_stb === 1'b1) sp_cnt <= sp_cnt + 1;
    if (cycles == 80000) begin
      errors++;
      close_out();
    end
  end
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic close_out();
    $display("compares %0d errors %0d", compares, errors);
    if (errors == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic cond(input int i, input logic v);
    @(posedge ref_clk);
    warn_cond[i] <= v;
  endtask
  // polls the status word, bounded, then judges the warning's state
  task automatic wait_w(input int i, input logic [1:0] v);
    logic [31:0] s;
    // start from a value that differs from the wanted one, so at least one read is made
    s = {16{~v}};
    for (int k = 0; k < 100 && s[2*i +: 2] !== v; k++) host.rd(8'h08, s);
    chk("warning state", {30'h0, v}, {30'h0, s[2*i +: 2]});
  endtask
  task automatic watch(input int n, output int rises, output int lit);
    logic prev;
    rises = 0;
    lit = 0;
    prev = lamp_red;
    repeat (n) begin
      @(posedge ref_clk);
      if (lamp_red === 1'b1) lit++;
      if (lamp_red === 1'b1 && prev !== 1'b1) rises++;
      prev = lamp_red;
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    host.rd(8'h00, q); chk("ctrl", 32'h4, q);
    host.rd(8'h04, q); chk("gdly", 32'h07d0_07d0, q);
    host.rd(8'h08, q); chk("stat", 32'h4000_0000, q);
    host.rd(8'h10, q); chk("wcfg", 32'h1, q);
    host.rd(8'h0c, q); chk("unmapped", 32'h0, q);
    chk("limit", 32'd100, {25'h0, drive_limit_pct});
  endtask
  // default 2000 ms delays, automatic recovery, fast pattern
  task automatic t_auto();
    cond(0, 1'b1);
    repeat (7950) @(posedge ref_clk);
    host.rd(8'h08, q); chk("early rise", 32'h0, {30'h0, q[1:0]});
    wait_w(0, 2'd1);
    watch(4000, r, l);
    chk("fast rises", 32'd2, r);
    chk("fast lit", 32'd2000, l);
    cond(0, 1'b0);
    repeat (7950) @(posedge ref_clk);
    host.rd(8'h08, q); chk("early fall", 32'h1, {30'h0, q[1:0]});
    wait_w(0, 2'd0);
    watch(4000, r, l);
    chk("auto lamp", 32'd0, l);
    host.wr(8'h04, 32'h0003_0003);
  endtask
  // resettable: cleared once by the button, once by the acknowledge bit
  task automatic t_resettable();
    host.wr(8'h00, 32'h14);
    for (int k = 0; k < 2; k++) begin
      cond(1, 1'b1);
      wait_w(1, 2'd1);
      cond(1, 1'b0);
      wait_w(1, 2'd2);
      watch(4000, r, l);
      chk("slow rises", 32'd1, r);
      chk("slow lit", 32'd2000, l);
      if (k == 0) begin
        @(posedge ref_clk);
        btn_reset <= 1'b1;
        @(posedge ref_clk);
        btn_reset <= 1'b0;
      end
      else host.wr(8'h00, 32'h15);
      wait_w(1, 2'd0);
      watch(400, r, l);
      chk("lamp after ack", 32'd0, l);
    end
    host.wr(8'h00, 32'h4);
  endtask
  task automatic t_individual();
    host.wr(8'h28, 32'h3);
    host.wr(8'h2c, 32'h0001_0014);
    cond(3, 1'b1);
    repeat (60) @(posedge ref_clk);
    host.rd(8'h08, q); chk("custom rise", 32'h0, {30'h0, q[7:6]});
    wait_w(3, 2'd1);
    cond(3, 1'b0);
    wait_w(3, 2'd0);
    host.wr(8'h20, 32'h15);
    cond(2, 1'b1);
    repeat (40) @(posedge ref_clk);
    watch(4000, r, l);
    chk("off lamp", 32'd0, l);
    host.rd(8'h08, q); chk("off stat", 32'h0, {30'h0, q[5:4]});
    cond(2, 1'b0);
    host.wr(8'h28, 32'h0);
    host.rd(8'h08, q); chk("disabled", 32'h3, {30'h0, q[7:6]});
  endtask
  task automatic t_actions();
    int d0, s0;
    for (int a = 1; a < 12; a++) begin
      host.wr(8'h10, 32'h201 | (a << 5));
      d0 = dev_cnt;
      s0 = sp_cnt;
      cond(0, 1'b1);
      wait_w(0, 2'd1);
      chk("action", {24'h0, exp_obs[a]}, {24'h0, dev_cnt != d0, sp_cnt != s0, meas_run,
          valve_ovr, sp_code, sw_out});
      cond(0, 1'b0);
      wait_w(0, 2'd0);
    end
    host.wr(8'h00, 32'hc);
    host.wr(8'h10, 32'h201 | (32'(WSM_A_SP0) << 5));
    s0 = sp_cnt;
    cond(0, 1'b1);
    wait_w(0, 2'd1);
    chk("analog only", 32'h2, {29'h0, sp_cnt != s0, sp_code});
    cond(0, 1'b0);
    wait_w(0, 2'd0);
    host.wr(8'h00, 32'h6);
    host.rd(8'h08, q); chk("host switch", 32'h1, {31'h0, q[27]});
    host.wr(8'h00, 32'h4);
    chk("host open", 32'h0, {31'h0, sw_out});
    host.wr(8'h10, 32'h401 | (32'(WSM_A_SWCLOSE) << 5));
    cond(0, 1'b1);
    wait_w(0, 2'd1);
    chk("no rise action", 32'h0, {31'h0, sw_out});
    cond(0, 1'b0);
    wait_w(0, 2'd0);
    chk("fall action", 32'h1, {31'h0, sw_out});
  endtask
  task automatic t_vprot();
    @(posedge ref_clk);
    {sp_nonzero, valve_full, flow_zero} <= 3'b111;
    repeat (30) @(posedge ref_clk);
    chk("vprot early", 32'h0, {31'h0, vprot_warn});
    for (int k = 0; k < 40 && vprot_warn !== 1'b1; k++) @(posedge ref_clk);
    chk("vprot", 32'h1, {31'h0, vprot_warn});
    chk("limit 75", 32'd75, {25'h0, drive_limit_pct});
    flow_zero <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("vprot end", 32'd100, {25'h0, drive_limit_pct});
    host.wr(8'h00, 32'h0);
    flow_zero <= 1'b1;
    repeat (80) @(posedge ref_clk);
    chk("vprot off", 32'h0, {31'h0, vprot_warn});
    flow_zero <= 1'b0;
    host.wr(8'h00, 32'h4);
  endtask
  // error beats an active warning: steady lamp
  task automatic t_error();
    cond(1, 1'b1);
    wait_w(1, 2'd1);
    err_det <= 1'b1;
    repeat (4) @(posedge ref_clk);
    watch(2100, r, l);
    chk("steady", 32'd2100, l);
    host.rd(8'h08, q); chk("err stat", 32'h1, {31'h0, q[24]});
  endtask
  // reset in mid-run drops the lamp, the held setpoint code and the delays back to defaults
  task automatic t_midreset();
    @(posedge ref_clk);
    {err_det, warn_cond} <= '0;
    rst_n <= 1'b0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    host.rd(8'h08, q); chk("stat after reset", 32'h4000_0000, q);
    host.rd(8'h04, q); chk("gdly after reset", 32'h07d0_07d0, q);
    chk("sp code after reset", 32'h0, {30'h0, sp_code});
  endtask
  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    warn_cond = '0;
    {err_det, btn_reset, flow_zero, valve_full, sp_nonzero} = '0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    t_reset();
    t_auto();
    t_resettable();
    t_individual();
    t_actions();
    t_vprot();
    t_error();
    t_midreset();
    close_out();
  end
endmodule // warning_status_manager_test
`default_nettype wire
